/* rtl/lrc_top.sv */
// Linear regulator bank control with Wishbone register access
module lrc_top
    import lrc_pkg::*;
#(
    parameter int RAMP_N = RAMP_CYC,
    parameter int DISCH_N = DISCH_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // System state and OTP image
    input wire logic standby_i,
    input wire logic powerup_load_i,
    input wire logic [lrc_pkg::NUM_REG-1:0] otp_in_sequence_i,
    input wire logic [lrc_pkg::NUM_REG-1:0] otp_switch_mode_bit_i,
    input wire logic [lrc_pkg::NUM_REG*lrc_pkg::VCODE_W-1:0] otp_default_voltage_code_i,
    input wire logic qualified_powerup_off_state_i,
    // Pins from the system processor
    input wire logic second_regulator_enable_pin_i,
    input wire logic voltage_choice_pin_i,
    // Regulator controls
    output logic [lrc_pkg::NUM_REG-1:0] regulator_on_o,
    output logic [lrc_pkg::NUM_REG-1:0] switch_mode_o,
    output logic [lrc_pkg::NUM_REG-1:0] pulldown_o,
    output logic [lrc_pkg::NUM_REG-1:0] weak_pulldown_o,
    output logic [lrc_pkg::NUM_REG-1:0] softstart_o,
    output logic [lrc_pkg::NUM_REG-1:0] discharge_o,
    output logic [lrc_pkg::NUM_REG-1:0] ilim_o,
    output logic [lrc_pkg::NUM_REG*lrc_pkg::VCODE_W-1:0] setpoint_o,
    output logic [lrc_pkg::NUM_REG*11-1:0] setpoint_mv_o
);
    import lrc_pkg::*;

    // ----------------------------------------
    // Voltage table in millivolts
    // ----------------------------------------
    function automatic logic [12:0] code_to_mv(input logic [3:0] c);
        unique case (c)
            4'h0: return 13'h05DC;
            4'h1: return 13'h0640;
            4'h2: return 13'h0708;
            4'h3: return 13'h073A;
            4'h4: return 13'h0866;
            4'h5: return 13'h09C4;
            4'h6: return 13'h0AF0;
            4'h7: return 13'h0BB8;
            4'h8: return 13'h0C1C;
            4'h9: return 13'h0C4E;
            4'hA: return 13'h0C80;
            4'hB: return 13'h0CE4;
            4'hC: return 13'h0D16;
            4'hD: return 13'h0672;
            4'hE: return 13'h06A4;
            4'hF: return 13'h1388;
        endcase
    endfunction

    // ----------------------------------------
    // Pin and system state synchronisers
    // ----------------------------------------
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] st_s1_q;
    logic [1:0] st_s2_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
            st_s1_q <= 2'h0;
            st_s2_q <= 2'h0;
        end else begin
            pin_s1_q <= {voltage_choice_pin_i, second_regulator_enable_pin_i};
            pin_s2_q <= pin_s1_q;
            st_s1_q <= {qualified_powerup_off_state_i, standby_i};
            st_s2_q <= st_s1_q;
        end
    end

    logic hw_en;
    logic hw_vsel;
    logic stby;
    logic qualified_powerup_off_state;
    assign hw_en = pin_s2_q[0];
    assign hw_vsel = pin_s2_q[1];
    assign stby = st_s2_q[0];
    assign qualified_powerup_off_state = st_s2_q[1];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [NUM_REG-1:0] run_enable_bit_q;
    logic [NUM_REG-1:0] standby_enable_bit_q;
    logic [VCODE_W-1:0] run_voltage_code_q [NUM_REG];
    logic [VCODE_W-1:0] standby_voltage_code_q [NUM_REG];
    logic [4:0] ctrl_q;
    logic [NUM_REG-1:0] ramp_w;
    logic [NUM_REG-1:0] disch_w;

    logic wr;
    logic rd;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_enable_bit_q <= RST_EN;
            standby_enable_bit_q <= RST_EN;
            ctrl_q <= RST_CTRL;
        end else if (powerup_load_i) begin
            run_enable_bit_q <= otp_in_sequence_i;
            standby_enable_bit_q <= otp_in_sequence_i;
        end else if (wr) begin
            if (wb_adr_i == ADDR_RUN_EN) begin
                run_enable_bit_q <= wb_dat_i[NUM_REG-1:0];
            end
            if (wb_adr_i == ADDR_STBY_EN) begin
                standby_enable_bit_q <= wb_dat_i[NUM_REG-1:0];
            end
            if (wb_adr_i == ADDR_CTRL) begin
                ctrl_q <= wb_dat_i[4:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REG; g++) begin : g_vreg
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    run_voltage_code_q[g] <= RST_VCODE;
                    standby_voltage_code_q[g] <= RST_VCODE;
                end else if (powerup_load_i) begin
                    run_voltage_code_q[g] <= otp_default_voltage_code_i[g*VCODE_W +: VCODE_W];
                    standby_voltage_code_q[g] <= otp_default_voltage_code_i[g*VCODE_W +: VCODE_W];
                end else if (wr && wb_adr_i == ADDR_RUN_V0 + 8'(4 * g)) begin
                    run_voltage_code_q[g] <= wb_dat_i[VCODE_W-1:0];
                end else if (wr && wb_adr_i == ADDR_STBY_V0 + 8'(4 * g)) begin
                    standby_voltage_code_q[g] <= wb_dat_i[VCODE_W-1:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Per-regulator selection and mode decode
    // ----------------------------------------
    logic [NUM_REG-1:0] en_sel;
    logic [VCODE_W-1:0] code_sel [NUM_REG];
    lrc_mode_e mode [NUM_REG];

    generate
        for (g = 0; g < NUM_REG; g++) begin : g_sel
            always_comb begin
                // Current state is the selector for both enable and code
                en_sel[g] = stby ? standby_enable_bit_q[g] : run_enable_bit_q[g];
                code_sel[g] = stby ? standby_voltage_code_q[g] : run_voltage_code_q[g];
                // Pins override software only for the hardware-controlled regulator
                if (g == HW_REG && ctrl_q[CTRL_HWCTL_BIT]) begin
                    en_sel[g] = hw_en;
                    code_sel[g] = hw_vsel ? standby_voltage_code_q[g] : run_voltage_code_q[g];
                end
                mode[g] = lrc_decode(en_sel[g], otp_switch_mode_bit_i[g]);
            end

            lrc_ramp #(
                .RAMP_N(RAMP_N),
                .DISCH_N(DISCH_N)
            ) u_ramp (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .on_i(en_sel[g]),
                .ramp_o(ramp_w[g]),
                .disch_o(disch_w[g])
            );

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    regulator_on_o[g] <= 1'b0;
                    switch_mode_o[g] <= 1'b0;
                    pulldown_o[g] <= 1'b1;
                    weak_pulldown_o[g] <= 1'b0;
                    ilim_o[g] <= 1'b0;
                    softstart_o[g] <= 1'b0;
                    discharge_o[g] <= 1'b0;
                    setpoint_o[g*VCODE_W +: VCODE_W] <= RST_VCODE;
                    setpoint_mv_o[g*11 +: 11] <= 11'h0;
                end else begin
                    regulator_on_o[g] <= (mode[g] != LRC_OFF_PD);
                    switch_mode_o[g] <= (mode[g] == LRC_SWITCH);
                    pulldown_o[g] <= (mode[g] == LRC_OFF_PD);
                    weak_pulldown_o[g] <= ctrl_q[CTRL_TBB_BIT] && qualified_powerup_off_state;
                    ilim_o[g] <= (mode[g] == LRC_SWITCH) && ctrl_q[CTRL_ILIM_LSB + g];
                    softstart_o[g] <= ramp_w[g];
                    discharge_o[g] <= disch_w[g];
                    setpoint_o[g*VCODE_W +: VCODE_W] <= code_sel[g];
                    // Tens of millivolts keep the bus to eleven bits
                    setpoint_mv_o[g*11 +: 11] <= 11'(code_to_mv(code_sel[g]) / 13'hA);
                end
            end

            // ----------------------------------------
            // Per-regulator checks
            // ----------------------------------------
            // Outputs trail the selection by one register stage, soft-start and discharge by two
            a_pd_in_run: assert property (@(posedge clk_i) disable iff (rst_i)
                (!stby && !run_enable_bit_q[g] && !(g == HW_REG && ctrl_q[CTRL_HWCTL_BIT]))
                |=> !regulator_on_o[g] && pulldown_o[g])
                else $error("run disable without pull-down");
            a_pd_off: assert property (@(posedge clk_i) disable iff (rst_i)
                !en_sel[g] |=> pulldown_o[g] && !switch_mode_o[g])
                else $error("off state without pull-down");
            a_normal: assert property (@(posedge clk_i) disable iff (rst_i)
                (en_sel[g] && !otp_switch_mode_bit_i[g])
                |=> regulator_on_o[g] && !switch_mode_o[g] && !pulldown_o[g])
                else $error("normal mode not taken");
            a_switch_open: assert property (@(posedge clk_i) disable iff (rst_i)
                (!en_sel[g] && otp_switch_mode_bit_i[g]) |=> !regulator_on_o[g])
                else $error("pass switch left closed");
            a_ilim_on: assert property (@(posedge clk_i) disable iff (rst_i)
                (mode[g] == LRC_SWITCH && ctrl_q[CTRL_ILIM_LSB + g]) |=> ilim_o[g])
                else $error("current limit not applied");
            a_weak_off: assert property (@(posedge clk_i) disable iff (rst_i)
                !(ctrl_q[CTRL_TBB_BIT] && qualified_powerup_off_state) |=> !weak_pulldown_o[g])
                else $error("weak pull-down outside test state");
            a_off_in_run: assert property (@(posedge clk_i) disable iff (rst_i)
                (!stby && !run_enable_bit_q[g] && !(g == HW_REG && ctrl_q[CTRL_HWCTL_BIT]))
                |=> !regulator_on_o[g])
                else $error("run disable not honoured");
            a_off_in_stby: assert property (@(posedge clk_i) disable iff (rst_i)
                (stby && !standby_enable_bit_q[g] && !(g == HW_REG && ctrl_q[CTRL_HWCTL_BIT]))
                |=> !regulator_on_o[g])
                else $error("standby disable not honoured");
            a_mode_ls: assert property (@(posedge clk_i) disable iff (rst_i)
                (en_sel[g] && otp_switch_mode_bit_i[g]) |=> switch_mode_o[g] && regulator_on_o[g])
                else $error("switch mode not taken");
            a_ilim: assert property (@(posedge clk_i) disable iff (rst_i)
                ilim_o[g] |-> $past(ctrl_q[CTRL_ILIM_LSB + g]) && switch_mode_o[g])
                else $error("current limit outside switch mode");
            a_ramp: assert property (@(posedge clk_i) disable iff (rst_i)
                $rose(en_sel[g]) |-> ##2 softstart_o[g] ##1 softstart_o[g])
                else $error("soft-start missing");
            a_disch: assert property (@(posedge clk_i) disable iff (rst_i)
                $fell(en_sel[g]) |-> ##2 discharge_o[g] && !softstart_o[g])
                else $error("discharge missing");
            a_run_code: assert property (@(posedge clk_i) disable iff (rst_i)
                (!stby && !(g == HW_REG && ctrl_q[CTRL_HWCTL_BIT]))
                |=> setpoint_o[g*VCODE_W +: VCODE_W] == $past(run_voltage_code_q[g]))
                else $error("run code not driven");
            a_stby_code: assert property (@(posedge clk_i) disable iff (rst_i)
                (stby && !(g == HW_REG && ctrl_q[CTRL_HWCTL_BIT]))
                |=> setpoint_o[g*VCODE_W +: VCODE_W] == $past(standby_voltage_code_q[g]))
                else $error("standby code not driven");
            a_otp_load: assert property (@(posedge clk_i) disable iff (rst_i)
                powerup_load_i |=> run_voltage_code_q[g] == standby_voltage_code_q[g])
                else $error("default code not loaded");
        end
    endgenerate

    a_hw_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_q[CTRL_HWCTL_BIT] && hw_en) |=> regulator_on_o[HW_REG])
        else $error("enable pin ignored");
    a_hw_pin_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_q[CTRL_HWCTL_BIT] && !hw_en) |=> !regulator_on_o[HW_REG])
        else $error("enable pin low ignored");
    // Pin picks the standby code; the run state plays no part here
    a_hw_vsel: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_q[CTRL_HWCTL_BIT] && hw_vsel)
        |=> setpoint_o[HW_REG*VCODE_W +: VCODE_W] == $past(standby_voltage_code_q[HW_REG]))
        else $error("voltage pin ignored");
    a_tbb: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_q[CTRL_TBB_BIT] && qualified_powerup_off_state) |=> &weak_pulldown_o)
        else $error("weak pull-down not connected");
    // Single-cycle acknowledge keeps one request from being taken twice
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held too long");

    // ----------------------------------------
    // Wishbone read path and acknowledge
    // ----------------------------------------
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0;
        for (int i = 0; i < NUM_REG; i++) begin
            if (wb_adr_i == ADDR_RUN_V0 + 8'(4 * i)) begin
                rdata = {28'h0, run_voltage_code_q[i]};
            end
            if (wb_adr_i == ADDR_STBY_V0 + 8'(4 * i)) begin
                rdata = {28'h0, standby_voltage_code_q[i]};
            end
            if (wb_adr_i == ADDR_SETPT) begin
                rdata[i*VCODE_W +: VCODE_W] = code_sel[i];
            end
        end
        unique case (wb_adr_i)
            ADDR_RUN_EN: rdata = {29'h0, run_enable_bit_q};
            ADDR_STBY_EN: rdata = {29'h0, standby_enable_bit_q};
            ADDR_CTRL: rdata = {27'h0, ctrl_q};
            ADDR_STATUS: rdata = {16'h0, stby, discharge_o, softstart_o, pulldown_o,
                                  switch_mode_o, regulator_on_o};
            default: ;
        endcase
    end

    // Unmapped addresses still acknowledge and read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= rd;
            wb_dat_o <= rd ? rdata : 32'h0;
        end
    end
endmodule

/* rtl/lrc_pkg.sv */
// Package: constants and types for the linear regulator control block
package lrc_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int NUM_REG = 3;
    localparam int VCODE_W = 4;
    localparam int HW_REG = 1;  // Index of the pin-controllable regulator

    // ----------------------------------------
    // Wishbone register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_RUN_EN = 8'h00;
    localparam logic [7:0] ADDR_STBY_EN = 8'h04;
    localparam logic [7:0] ADDR_RUN_V0 = 8'h08;
    localparam logic [7:0] ADDR_STBY_V0 = 8'h14;
    localparam logic [7:0] ADDR_CTRL = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_SETPT = 8'h28;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_ILIM_LSB = 0;  // Three bits, one per regulator
    localparam int CTRL_HWCTL_BIT = 3;
    localparam int CTRL_TBB_BIT = 4;
    localparam int STAT_ON_LSB = 0;
    localparam int STAT_LS_LSB = 3;
    localparam int STAT_PD_LSB = 6;
    localparam int STAT_RAMP_LSB = 9;
    localparam int STAT_DIS_LSB = 12;
    localparam int STAT_STBY_BIT = 15;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [2:0] RST_EN = 3'h0;
    localparam logic [3:0] RST_VCODE = 4'h0;
    localparam logic [4:0] RST_CTRL = 5'h0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int RAMP_US = 360;   // Soft-start ramp, longest
    localparam int DISCH_US = 3500; // Discharge window, longest
    localparam int RAMP_CYC = RAMP_US * CLK_MHZ;
    localparam int DISCH_CYC = DISCH_US * CLK_MHZ;
    localparam int TMR_W = 20;

    // ----------------------------------------
    // Operating modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        LRC_OFF_PD = 2'b00,
        LRC_NORMAL = 2'b01,
        LRC_SWITCH = 2'b10
    } lrc_mode_e;

    // Mode decode from enable and OTP switch-mode bit
    function automatic lrc_mode_e lrc_decode(input logic en, input logic ls);
        if (!en) begin
            return LRC_OFF_PD;
        end
        return ls ? LRC_SWITCH : LRC_NORMAL;
    endfunction
endpackage

/* rtl/lrc_ramp.sv */
// Per-regulator soft-start and discharge timer
module lrc_ramp
    import lrc_pkg::*;
#(
    parameter int RAMP_N = RAMP_CYC,
    parameter int DISCH_N = DISCH_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic on_i,
    output logic ramp_o,
    output logic disch_o
);
    logic on_q;
    logic [TMR_W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_q <= 1'b0;
        end else begin
            on_q <= on_i;
        end
    end

    // A new edge restarts the timer, so a quick off-on cannot skip the ramp
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            ramp_o <= 1'b0;
            disch_o <= 1'b0;
        end else if (on_i && !on_q) begin
            cnt_q <= TMR_W'(RAMP_N - 1);
            ramp_o <= 1'b1;
            disch_o <= 1'b0;
        end else if (!on_i && on_q) begin
            cnt_q <= TMR_W'(DISCH_N - 1);
            ramp_o <= 1'b0;
            disch_o <= 1'b1;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - TMR_W'(1);
        end else begin
            ramp_o <= 1'b0;
            disch_o <= 1'b0;
        end
    end
endmodule

/* test/lrc_pin_model.sv */
// Behavioural system processor that drives the regulator two pins
module lrc_pin_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic en_i,
    input wire logic sel_i,
    input wire logic slow_i,
    output logic en_pin_o,
    output logic sel_pin_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] wait_q;
    // Slow answers move the pins long after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_pin_o <= 1'b0;
            sel_pin_o <= 1'b0;
            busy_o <= 1'b0;
            wait_q <= 5'h00;
        end else if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            wait_q <= slow_i ? 5'h14 : 5'h00;
        end else if (busy_o && wait_q != 5'h00) begin
            wait_q <= wait_q - 5'h01;
        end else if (busy_o) begin
            en_pin_o <= en_i;
            sel_pin_o <= sel_i;
            busy_o <= 1'b0;
        end
    end
endmodule

/* test/lrc_top_tb_top.sv */
// Self-checking bench for the linear regulator control block
module lrc_top_tb_top
    import lrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, we = 1'b0, standby = 1'b0, load = 1'b0, qpu = 1'b0, look = 1'b0;
    logic go = 1'b0, pen = 1'b0, psel = 1'b0, slow = 1'b0, en_pin, sel_pin, busy, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, me;
    logic [2:0] seq = 3'h0, ls = 3'h0, on, swm, pd, wpd, ss, dis, ilim;
    logic [11:0] codes = 12'h000, sb = 12'h000, sp;
    logic [32:0] mv;
    logic [3:0] mk;
    logic [3:0] kind_q[$];
    logic [31:0] exp_q[$];
    int fails = 0, checks = 0, seed = 97345;
    int mv_tab[16] = '{150, 160, 180, 185, 215, 250, 280, 300, 310, 315, 320, 330, 335,
                       165, 170, 500};

    always #2.5 clk_i = ~clk_i;

    // Short ramp and discharge counts keep the run brief
    lrc_top #(.RAMP_N(8), .DISCH_N(16)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .standby_i(standby), .powerup_load_i(load), .otp_in_sequence_i(seq),
        .otp_switch_mode_bit_i(ls), .otp_default_voltage_code_i(codes),
        .qualified_powerup_off_state_i(qpu), .second_regulator_enable_pin_i(en_pin),
        .voltage_choice_pin_i(sel_pin), .regulator_on_o(on), .switch_mode_o(swm),
        .pulldown_o(pd), .weak_pulldown_o(wpd), .softstart_o(ss), .discharge_o(dis),
        .ilim_o(ilim), .setpoint_o(sp), .setpoint_mv_o(mv));

    lrc_pin_model partner (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .en_i(pen),
        .sel_i(psel), .slow_i(slow), .en_pin_o(en_pin), .sel_pin_o(sel_pin), .busy_o(busy));

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    function automatic logic [31:0] port(input logic [3:0] k);
        case (k)
            4'h0: return rdat;
            4'h1: return 32'(on);
            4'h2: return 32'(swm);
            4'h3: return 32'(pd);
            4'h4: return 32'(wpd);
            4'h5: return 32'(ss);
            4'h6: return 32'(dis);
            4'h7: return 32'(ilim);
            4'h8: return 32'(sp);
            4'h9: return 32'(mv[10:0]);
            default: return 32'(sp[7:4]);
        endcase
    endfunction

    task automatic print_verdict;
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t ns: seen %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic give_up;
        fails++;
        $display("unexpected at %0t ns: wait ran out", $time);
        print_verdict();
    endtask

    // Notes are taken in order, so reads and port looks never overlap
    always @(posedge clk_i) begin
        if (look || (ack === 1'b1 && we === 1'b0)) begin
            if (kind_q.size() == 0) begin
                fails++;
                $display("unexpected at %0t ns: result with no pending note", $time);
            end else begin
                mk = kind_q.pop_front();
                me = exp_q.pop_front();
                check(port(mk), me);
            end
        end
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task automatic note(input logic [3:0] k, input logic [31:0] e);
        kind_q.push_back(k);
        exp_q.push_back(e);
        look <= 1'b1;
        @(posedge clk_i);
        look <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (n >= 16) give_up();
        cyc <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        kind_q.push_back(4'h0);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic settle;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic wait_hi(input logic [3:0] k, input int b);
        int n;
        logic [31:0] v;
        n = 0;
        do begin
            @(posedge clk_i);
            v = port(k);
            n++;
        end while (v[b] !== 1'b1 && n < 8);
        if (n >= 8) give_up();
    endtask

    task automatic pins(input logic e, input logic s, input logic sl);
        int n;
        n = 0;
        @(posedge clk_i);
        pen <= e;
        psel <= s;
        slow <= sl;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 40);
        if (n >= 40) give_up();
        settle();
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        note(4'h1, 32'h0);
        note(4'h3, 32'h7);
        rd(ADDR_RUN_EN, 32'h0);
        @(posedge clk_i);
        seq <= 3'h5;
        ls <= 3'h4;
        codes <= 12'($random(seed));
        sb <= 12'($random(seed));
        load <= 1'b1;
        @(posedge clk_i);
        load <= 1'b0;
        rd(ADDR_RUN_EN, 32'h5);
        rd(ADDR_STBY_EN, 32'h5);
        for (int i = 0; i < 3; i++) begin
            rd(ADDR_RUN_V0 + 8'(4 * i), 32'(codes[4*i+:4]));
            rd(ADDR_STBY_V0 + 8'(4 * i), 32'(codes[4*i+:4]));
        end
        rd(8'h30, 32'h0);
        settle();
        note(4'h1, 32'h5);
        note(4'h2, 32'h4);
        note(4'h3, 32'h2);
        note(4'h8, 32'(codes));
        wb(1'b1, ADDR_STBY_EN, 32'h3);
        for (int i = 0; i < 3; i++) wb(1'b1, ADDR_STBY_V0 + 8'(4 * i), 32'(sb[4*i+:4]));
        settle();
        note(4'h1, 32'h5);
        @(posedge clk_i);
        standby <= 1'b1;
        settle();
        note(4'h1, 32'h3);
        note(4'h8, 32'(sb));
        note(4'h2, 32'h0);
        note(4'h3, 32'h4);
        @(posedge clk_i);
        standby <= 1'b0;
        settle();
        note(4'h8, 32'(codes));
        for (int i = 0; i < 16; i++) begin
            wb(1'b1, ADDR_RUN_V0, 32'(i));
            settle();
            note(4'h9, 32'(mv_tab[i]));
        end
        wb(1'b1, ADDR_CTRL, 32'h7);
        settle();
        note(4'h7, 32'h4);
        wb(1'b1, ADDR_CTRL, 32'h0);
        settle();
        note(4'h7, 32'h0);
        wb(1'b1, ADDR_CTRL, 32'h10);
        @(posedge clk_i);
        qpu <= 1'b1;
        settle();
        note(4'h4, 32'h7);
        qpu <= 1'b0;
        settle();
        note(4'h4, 32'h0);
        wb(1'b1, ADDR_RUN_EN, 32'h7);
        wait_hi(4'h5, 1);
        repeat (3) @(posedge clk_i);
        note(4'h5, 32'h2);
        repeat (12) @(posedge clk_i);
        note(4'h5, 32'h0);
        wb(1'b1, ADDR_RUN_EN, 32'h5);
        wait_hi(4'h6, 1);
        repeat (6) @(posedge clk_i);
        note(4'h6, 32'h2);
        repeat (16) @(posedge clk_i);
        note(4'h6, 32'h0);
        wb(1'b1, ADDR_CTRL, 32'h8);
        pins(1'b1, 1'b0, 1'b0);
        note(4'h1, 32'h7);
        note(4'hA, 32'(codes[7:4]));
        pins(1'b1, 1'b1, 1'b1);
        note(4'hA, 32'(sb[7:4]));
        pins(1'b0, 1'b1, 1'b0);
        note(4'h1, 32'h5);
        print_verdict();
    end
endmodule
